// File: verilog/sioc_consts.vh
// constants for the serial i/o command engine
// Overview of operation
// - code 1130h dials the modem; block length includes the packed dial string.
// - the first parameter word of a dial is the response timeout in seconds.
// - word 8 of a dial gives the string byte count; exactly that many are sent.
// - string bytes pack two per word, low byte first, and go out low byte first.
// - code 1131h transmits one to 250 characters from word memory per request.
// - a transmit completes only when all characters are sent, or on its timeout.
// - a zero transmit timeout becomes the send time plus four seconds.
// - every 8-bit character value is sent unchanged, none filtered.
// - port initialise or cancel-all/cancel-write stops a running transmission.
// - code 1132h reads characters from the receive buffer into the named area.
// - a zero-count read completes at once, returning only the buffered count.
// - a read waits for enough characters or timeout; port status records which.
// - a read writes its status word only when it finishes.
// - a read with zero timeout waits without limit until served or cancelled.
// - a failed read writes no characters and keeps all buffered ones.
// - read results: count read, count still buffered, then packed characters.
// - an odd byte count clears the high byte of the last word written.
// - received characters are buffered; when full they drop and overflow sets.
// - read parameters: timeout, byte count, destination type, destination address.
// - header: block length, nonblocking word, status type, status address minus one.
// - framing and parity flags set on error and clear on a port status read.
// - cancel type 1 aborts everything, 2 aborts reads, 3 aborts writes.
`ifndef SIOC_CONSTS_VH
`define SIOC_CONSTS_VH
`define SIOC_CMD_DIAL   16'h1130
`define SIOC_CMD_WRITE  16'h1131
`define SIOC_CMD_READ   16'h1132
`define SIOC_CMD_INIT   16'h10cc
`define SIOC_CAN_ALL    2'h1
`define SIOC_CAN_READ   2'h2
`define SIOC_CAN_WRITE  2'h3
`define SIOC_OFF_STAT   4'h3
`define SIOC_OFF_CMD    4'h6
`define SIOC_OFF_TMO    4'h7
`define SIOC_OFF_CNT    4'h8
`define SIOC_OFF_DATA   4'h9
`define SIOC_OFF_DST    4'ha
`define SIOC_MAX_TX     16'h00fa
`define SIOC_TX_PAD_S   16'h0004
`define SIOC_STAT_OK    16'h0001
`define SIOC_STAT_TMO   16'h0002
`define SIOC_STAT_BAD   16'h0004
`define SIOC_BITS_CHAR  10
`endif

// File: verilog/sioc_pair_buf.v
// two-entry valid/ready buffer in the transmit byte path
`timescale 1ns/1ps
`default_nettype none
module sioc_pair_buf #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] tail;
    reg             tail_v;
    wire            push;
    wire            pop;

    // ready comes from a flop, so a stalled sink never forms a combinational loop
    assign in_ready = ~tail_v;
    assign push     = in_valid & ~tail_v;
    assign pop      = out_valid & out_ready;

    always @(posedge clk_sys)
    begin
        if (!rst_n || flush)
        begin
            out_valid <= 1'b0;
            tail_v    <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
            tail      <= {WIDTH{1'b0}};
        end
        else if (pop || !out_valid)
        begin
            if (tail_v)
            begin
                out_data  <= tail;
                out_valid <= 1'b1;
                tail_v    <= push;
                if (push)
                    tail <= in_data;
            end
            else
            begin
                out_valid <= push;
                if (push)
                    out_data <= in_data;
            end
        end
        else if (push)
        begin
            tail   <= in_data;
            tail_v <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: verilog/sioc_engine.v
// command block interpreter driving one serial port
`timescale 1ns/1ps
`default_nettype none
`include "sioc_consts.vh"
module sioc_engine #(
    parameter CLK_HZ   = 20000000,
    parameter BAUD     = 9600,
    parameter RX_DEPTH = 64,
    parameter RX_AW    = 6
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        cmd_start,
    input  wire [15:0] cmd_base,
    output reg         cmd_busy,
    output reg         cmd_done,
    output reg  [15:0] cmd_status,
    input  wire        init_req,
    input  wire        cancel_req,
    input  wire [1:0]  cancel_type,
    input  wire        status_read,
    output reg         mem_rd,
    output reg         mem_wr,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    output wire [7:0]  tx_data,
    output wire        tx_valid,
    input  wire        tx_ready,
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    input  wire        rx_framing_err,
    input  wire        rx_parity_err,
    output reg         overflow_flag,
    output reg         framing_error_flag,
    output reg         parity_error_flag,
    output reg         read_timeout_flag,
    output reg  [15:0] rx_level
);
    localparam ST_IDLE   = 4'h0;
    localparam ST_FETCH  = 4'h1;
    localparam ST_MWAIT  = 4'h2;
    localparam ST_CAP    = 4'h3;
    localparam ST_FSTORE = 4'h4;
    localparam ST_DECODE = 4'h5;
    localparam ST_TX_RD  = 4'h6;
    localparam ST_TX_PSH = 4'h7;
    localparam ST_TX_DRN = 4'h8;
    localparam ST_RD_WT  = 4'h9;
    localparam ST_RD_HDR = 4'ha;
    localparam ST_RD_POP = 4'hb;
    localparam ST_RD_WR  = 4'hc;
    localparam ST_STAT   = 4'hd;

    reg [3:0]  state;
    reg [3:0]  ret;
    reg [3:0]  idx;
    reg [15:0] word;
    reg [15:0] stat_addr;
    reg [15:0] cmd;
    reg [15:0] tmo_s;
    reg [15:0] cnt;
    reg [15:0] dst;
    reg [15:0] ptr;
    reg [15:0] done_n;
    reg [15:0] status;
    reg        half;
    reg        hstep;
    reg [24:0] sec_cnt;
    reg [15:0] tmo_left;
    reg        tmo_en;
    reg        tmr_load;
    reg [15:0] tmr_val;
    reg        tx_flush;
    reg        rx_flush;

    reg [7:0]       rx_mem [0:RX_DEPTH-1];
    reg [RX_AW-1:0] rx_wp;
    reg [RX_AW-1:0] rx_rp;
    reg [RX_AW:0]   rx_count;

    wire        buf_in_valid;
    wire        buf_in_ready;
    wire [7:0]  buf_in_data;
    wire        tmo_hit;
    wire        sec_tick;
    wire        rx_full;
    wire        rx_push;
    wire        rx_pop;
    wire [15:0] rx_have;
    wire [31:0] tx_secs;
    wire        abort_tx;
    wire        abort_rd;

    assign rx_have  = {{(15-RX_AW){1'b0}}, rx_count};
    assign rx_full  = (rx_count == RX_DEPTH[RX_AW:0]);
    assign rx_push  = rx_valid & ~rx_full & ~rx_flush;
    assign rx_pop   = (state == ST_RD_POP);
    assign sec_tick = (sec_cnt == CLK_HZ[24:0] - 25'd1);
    assign tmo_hit  = tmo_en & (tmo_left == 16'h0000);
    // send time rounds up to whole seconds before the fixed margin is added
    assign tx_secs  = ({16'h0000, cnt} * `SIOC_BITS_CHAR + BAUD - 1) / BAUD
                      + {16'h0000, `SIOC_TX_PAD_S};
    assign abort_tx = init_req | (cancel_req & (cancel_type == `SIOC_CAN_ALL
                      | cancel_type == `SIOC_CAN_WRITE));
    assign abort_rd = init_req | (cancel_req & (cancel_type == `SIOC_CAN_ALL
                      | cancel_type == `SIOC_CAN_READ));
    assign buf_in_valid = (state == ST_TX_PSH);
    // bytes pass untouched, any of the 256 values is legal
    assign buf_in_data  = half ? word[15:8] : word[7:0];

    sioc_pair_buf #(
        .WIDTH     (8)
    ) u_tx_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .flush     (tx_flush),
        .in_data   (buf_in_data),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // one-second tick restarts on each load so the first second is whole
    always @(posedge clk_sys)
    begin
        if (!rst_n || tmr_load || sec_tick)
            sec_cnt <= 25'd0;
        else
            sec_cnt <= sec_cnt + 25'd1;
        if (!rst_n)
        begin
            tmo_left <= 16'h0000;
            tmo_en   <= 1'b0;
        end
        else if (tmr_load)
        begin
            tmo_left <= tmr_val;
            tmo_en   <= (tmr_val != 16'h0000);
        end
        else if (state == ST_IDLE)
            tmo_en <= 1'b0;
        else if (sec_tick && tmo_left != 16'h0000)
            tmo_left <= tmo_left - 16'h0001;
    end

    // receive buffer; a full buffer drops the byte rather than stall the port
    always @(posedge clk_sys)
    begin
        if (!rst_n || rx_flush)
        begin
            rx_wp    <= {RX_AW{1'b0}};
            rx_rp    <= {RX_AW{1'b0}};
            rx_count <= {(RX_AW+1){1'b0}};
        end
        else
        begin
            if (rx_push)
            begin
                rx_mem[rx_wp] <= rx_data;
                rx_wp         <= rx_wp + {{(RX_AW-1){1'b0}}, 1'b1};
            end
            if (rx_pop)
                rx_rp <= rx_rp + {{(RX_AW-1){1'b0}}, 1'b1};
            if (rx_push && !rx_pop)
                rx_count <= rx_count + {{RX_AW{1'b0}}, 1'b1};
            else if (rx_pop && !rx_push)
                rx_count <= rx_count - {{RX_AW{1'b0}}, 1'b1};
        end
    end

    // error flags: an event in the clearing cycle wins over the clear
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            overflow_flag      <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag  <= 1'b0;
            rx_level           <= 16'h0000;
        end
        else
        begin
            overflow_flag      <= (rx_valid & rx_full) | (overflow_flag & ~status_read);
            framing_error_flag <= rx_framing_err | (framing_error_flag & ~status_read);
            parity_error_flag  <= rx_parity_err | (parity_error_flag & ~status_read);
            rx_level           <= rx_have;
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state             <= ST_IDLE;
            ret               <= ST_IDLE;
            idx               <= 4'h0;
            word              <= 16'h0000;
            stat_addr         <= 16'h0000;
            cmd               <= 16'h0000;
            tmo_s             <= 16'h0000;
            cnt               <= 16'h0000;
            dst               <= 16'h0000;
            ptr               <= 16'h0000;
            done_n            <= 16'h0000;
            status            <= 16'h0000;
            half              <= 1'b0;
            hstep             <= 1'b0;
            tmr_load          <= 1'b0;
            tmr_val           <= 16'h0000;
            tx_flush          <= 1'b0;
            rx_flush          <= 1'b0;
            cmd_busy          <= 1'b0;
            cmd_done          <= 1'b0;
            cmd_status        <= 16'h0000;
            read_timeout_flag <= 1'b0;
            mem_rd            <= 1'b0;
            mem_wr            <= 1'b0;
            mem_addr          <= 16'h0000;
            mem_wdata         <= 16'h0000;
        end
        else
        begin
            mem_rd   <= 1'b0;
            mem_wr   <= 1'b0;
            cmd_done <= 1'b0;
            tmr_load <= 1'b0;
            tx_flush <= 1'b0;
            rx_flush <= init_req;
            case (state)
                ST_IDLE:
                begin
                    if (cmd_start)
                    begin
                        cmd_busy <= 1'b1;
                        idx      <= `SIOC_OFF_STAT;
                        state    <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    mem_rd   <= 1'b1;
                    mem_addr <= cmd_base + {12'h000, idx};
                    ret      <= ST_FSTORE;
                    state    <= ST_MWAIT;
                end
                ST_MWAIT:
                    state <= ST_CAP;
                ST_CAP:
                begin
                    word  <= mem_rdata;
                    state <= ret;
                end
                ST_FSTORE:
                begin
                    case (idx)
                        `SIOC_OFF_STAT: stat_addr <= word + 16'h0001;
                        `SIOC_OFF_CMD:  cmd <= word;
                        `SIOC_OFF_TMO:  tmo_s <= word;
                        `SIOC_OFF_CNT:  cnt <= word;
                        `SIOC_OFF_DST:  dst <= word;
                        default:        cmd <= cmd;
                    endcase
                    idx   <= idx + 4'h1;
                    state <= (idx == `SIOC_OFF_DST) ? ST_DECODE : ST_FETCH;
                end
                ST_DECODE:
                begin
                    half   <= 1'b0;
                    hstep  <= 1'b0;
                    done_n <= 16'h0000;
                    if (cmd == `SIOC_CMD_DIAL || cmd == `SIOC_CMD_WRITE)
                    begin
                        if (cnt == 16'h0000 || cnt > `SIOC_MAX_TX)
                        begin
                            status <= `SIOC_STAT_BAD;
                            state  <= ST_STAT;
                        end
                        else
                        begin
                            tmr_load <= 1'b1;
                            tmr_val  <= (tmo_s == 16'h0000) ? tx_secs[15:0] : tmo_s;
                            ptr      <= cmd_base + {12'h000, `SIOC_OFF_DATA};
                            state    <= ST_TX_RD;
                        end
                    end
                    else if (cmd == `SIOC_CMD_READ)
                    begin
                        tmr_load <= 1'b1;
                        tmr_val  <= tmo_s;
                        // nothing asked for: report the level and finish
                        state    <= (cnt == 16'h0000) ? ST_RD_HDR : ST_RD_WT;
                    end
                    else if (cmd == `SIOC_CMD_INIT)
                    begin
                        rx_flush <= 1'b1;
                        tx_flush <= 1'b1;
                        status   <= `SIOC_STAT_OK;
                        state    <= ST_STAT;
                    end
                    else
                    begin
                        status <= `SIOC_STAT_BAD;
                        state  <= ST_STAT;
                    end
                end
                ST_TX_RD:
                begin
                    mem_rd   <= 1'b1;
                    mem_addr <= ptr;
                    ret      <= ST_TX_PSH;
                    state    <= ST_MWAIT;
                end
                ST_TX_PSH:
                begin
                    if (buf_in_ready)
                    begin
                        done_n <= done_n + 16'h0001;
                        half   <= ~half;
                        if (done_n + 16'h0001 == cnt)
                            state <= ST_TX_DRN;
                        else if (half)
                        begin
                            ptr   <= ptr + 16'h0001;
                            state <= ST_TX_RD;
                        end
                    end
                end
                ST_TX_DRN:
                begin
                    // done only once the port has taken the last byte
                    if (!tx_valid)
                    begin
                        status <= `SIOC_STAT_OK;
                        state  <= ST_STAT;
                    end
                end
                ST_RD_WT:
                begin
                    if (rx_have >= cnt)
                    begin
                        read_timeout_flag <= 1'b0;
                        state             <= ST_RD_HDR;
                    end
                    else if (tmo_hit)
                    begin
                        // nothing leaves the buffer on a failed read
                        read_timeout_flag <= 1'b1;
                        status            <= `SIOC_STAT_TMO;
                        state             <= ST_STAT;
                    end
                end
                ST_RD_HDR:
                begin
                    mem_wr    <= 1'b1;
                    hstep     <= 1'b1;
                    mem_addr  <= hstep ? dst + 16'h0001 : dst;
                    mem_wdata <= hstep ? rx_have - cnt : cnt;
                    ptr       <= dst + 16'h0002;
                    if (hstep)
                    begin
                        status <= `SIOC_STAT_OK;
                        state  <= (cnt == 16'h0000) ? ST_STAT : ST_RD_POP;
                    end
                end
                ST_RD_POP:
                begin
                    done_n <= done_n + 16'h0001;
                    half   <= ~half;
                    if (half)
                    begin
                        word[15:8] <= rx_mem[rx_rp];
                        state      <= ST_RD_WR;
                    end
                    else
                    begin
                        word <= {8'h00, rx_mem[rx_rp]};
                        if (done_n + 16'h0001 == cnt)
                            state <= ST_RD_WR;
                    end
                end
                ST_RD_WR:
                begin
                    mem_wr    <= 1'b1;
                    mem_addr  <= ptr;
                    mem_wdata <= word;
                    ptr       <= ptr + 16'h0001;
                    state     <= (done_n == cnt) ? ST_STAT : ST_RD_POP;
                end
                ST_STAT:
                begin
                    mem_wr     <= 1'b1;
                    mem_addr   <= stat_addr;
                    mem_wdata  <= status;
                    cmd_status <= status;
                    cmd_done   <= 1'b1;
                    cmd_busy   <= 1'b0;
                    state      <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
            // cancel leaves the status word untouched; a timeout ends a stuck send
            if ((state == ST_TX_RD || state == ST_TX_PSH || state == ST_TX_DRN
                 || ((state == ST_MWAIT || state == ST_CAP) && ret == ST_TX_PSH)))
            begin
                if (abort_tx)
                begin
                    tx_flush <= 1'b1;
                    cmd_busy <= 1'b0;
                    state    <= ST_IDLE;
                end
                else if (tmo_hit)
                begin
                    tx_flush <= 1'b1;
                    status   <= `SIOC_STAT_TMO;
                    state    <= ST_STAT;
                end
            end
            if (state == ST_RD_WT && abort_rd)
            begin
                cmd_busy <= 1'b0;
                state    <= ST_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/sioc_engine_props.sv
// assertion checker for the serial command engine ports
`timescale 1ns/1ps
`default_nettype none
module sioc_engine_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        cmd_busy,
    input wire logic        cmd_done,
    input wire logic [15:0] cmd_status,
    input wire logic        mem_wr,
    input wire logic [15:0] mem_wdata,
    input wire logic        init_req,
    input wire logic        cancel_req,
    input wire logic        status_read,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        rx_valid,
    input wire logic        rx_framing_err,
    input wire logic        rx_parity_err,
    input wire logic        overflow_flag,
    input wire logic        framing_error_flag,
    input wire logic        parity_error_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    done_write_a: assert property (cmd_done |-> mem_wr) else $error("done without status write");
    status_copy_a: assert property (cmd_done |=> cmd_status == $past(mem_wdata)) else $error("status lost");
    frame_set_a: assert property (rx_framing_err |=> framing_error_flag) else $error("framing flag");
    parity_set_a: assert property (rx_parity_err |=> parity_error_flag) else $error("parity flag");
    flag_clear_a: assert property (status_read && !rx_framing_err && !rx_parity_err |=>
        !framing_error_flag && !parity_error_flag) else $error("flags not cleared");
    ovf_cause_a: assert property ($rose(overflow_flag) |-> $past(rx_valid)) else $error("overflow cause");
    // a flush on abort may empty the buffer, so those cycles are left out
    tx_hold_a: assert property (tx_valid && !tx_ready && !init_req && !cancel_req && !$past(init_req)
        && !$past(cancel_req) |=> tx_valid && $stable(tx_data)) else $error("byte changed while stalled");
    abort_idle_a: assert property (init_req && cmd_busy |-> ##[1:4] !cmd_busy) else $error("abort ignored");
    cover property (cmd_done && cmd_status == 16'h0002);
    cover property ($rose(overflow_flag));
    cover property (tx_valid && tx_ready && cmd_busy);
endmodule
bind sioc_engine sioc_engine_props u_props (.*);
`default_nettype wire

// File: tb/sioc_peer.sv
// remote serial device model on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module sioc_peer (
    input  wire logic       clk_sys,
    input  wire logic [1:0] pace,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid
);
    logic [7:0] got[$];
    int         n = 0;
    initial
    begin
        tx_ready = 0;
        rx_data = 0;
        rx_valid = 0;
    end
    // pace 0 prompt, 1 one grant in four, 2 holds flow control off for good
    always @(negedge clk_sys)
    begin
        n <= n + 1;
        tx_ready <= (pace == 2'h0) || (pace == 2'h1 && n[1:0] == 2'h0);
    end
    always @(posedge clk_sys)
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        rx_data = b;
        rx_valid = 1;
        @(negedge clk_sys);
        rx_valid = 0;
        rx_data = ~b; // idle data is junk, never the last byte
    endtask
endmodule
`default_nettype wire

// File: tb/sioc_engine_tb_top.sv
// self-checking bench for the serial command engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("Error t=%0t %h %h", $time, g, e); end end
module sioc_engine_tb_top;
    logic        clk_sys, rst_n, cmd_start, cmd_busy, cmd_done, init_req, cancel_req, status_read, d;
    logic        mem_rd, mem_wr, tx_valid, tx_ready, rx_valid, rx_framing_err, rx_parity_err;
    logic        overflow_flag, framing_error_flag, parity_error_flag, read_timeout_flag;
    logic [15:0] cmd_base, cmd_status, mem_addr, mem_wdata, mem_rdata, rx_level;
    logic [7:0]  tx_data, rx_data;
    logic [1:0]  cancel_type, pace;
    logic [15:0] mem [0:255];
    int          fails = 0;
    int          n_checks = 0;
    // a short second keeps each second of a timeout at a hundred cycles
    sioc_engine #(.CLK_HZ(100), .RX_DEPTH(4), .RX_AW(2)) u_dut (.*);
    sioc_peer u_peer (.*);
    initial
    begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys)
    begin
        if (mem_rd)
            mem_rdata <= mem[mem_addr[7:0]];
        if (mem_wr)
            mem[mem_addr[7:0]] <= mem_wdata;
    end
    task automatic wdone(input int lim);
        d = 0;
        for (int i = 0; i < lim && !d; i++)
        begin
            @(negedge clk_sys);
            d = cmd_done;
        end
        @(negedge clk_sys);
    endtask
    task automatic cmd(input logic [15:0] code, tmo, cnt, w9, w10, input int lim);
        mem[16] = 16'h000a;
        mem[18] = 16'h0008;
        mem[19] = 16'h0003;
        mem[22] = code;
        mem[23] = tmo;
        mem[24] = cnt;
        mem[25] = w9;
        mem[26] = w10;
        mem[4] = 16'hdead;
        @(negedge clk_sys);
        cmd_base = 16'h0010;
        cmd_start = 1;
        @(negedge clk_sys);
        cmd_start = 0;
        wdone(lim);
    endtask
    task automatic pulse(input int k);
        @(negedge clk_sys);
        {init_req, cancel_req, status_read, rx_framing_err, rx_parity_err} = 5'h10 >> k;
        @(negedge clk_sys);
        {init_req, cancel_req, status_read, rx_framing_err, rx_parity_err} = '0;
    endtask
    task automatic t_write;
        logic [7:0] e[5] = '{8'h00, 8'hff, 8'h0d, 8'h80, 8'h7f};
        pace = 2'h1;
        mem[27] = 16'h007f;
        cmd(16'h1131, 16'h001e, 16'h0005, 16'hff00, 16'h800d, 400);
        `CHK({d, mem[4], cmd_status}, {1'b1, 16'h0001, 16'h0001})
        `CHK(u_peer.got.size(), 5)
        foreach (e[i]) `CHK(u_peer.got[i], e[i])
        $display("write test done");
    endtask
    task automatic t_dial;
        logic [15:0] c[3] = '{16'h1130, 16'h1131, 16'h1234};
        logic [15:0] n[3] = '{16'h0000, 16'h00fb, 16'h0001};
        pace = 2'h0;
        foreach (c[i])
        begin
            cmd(c[i], 16'h001e, n[i], 16'h0000, 16'h0000, 200);
            `CHK(mem[4], 16'h0004)
        end
        u_peer.got.delete();
        cmd(16'h1130, 16'h001e, 16'h0003, 16'h5441, 16'h000d, 300);
        `CHK(u_peer.got.size(), 3)
        `CHK({u_peer.got[2], u_peer.got[1], u_peer.got[0]}, 24'h0d5441)
        $display("dial test done");
    endtask
    task automatic t_read;
        u_peer.send(8'h11);
        u_peer.send(8'h22);
        u_peer.send(8'h33);
        mem[66] = 16'hbeef;
        mem[67] = 16'hffff;
        cmd(16'h1132, 16'h001e, 16'h0000, 16'h0008, 16'h0040, 200);
        `CHK({mem[64], mem[65], mem[66]}, 48'h0000_0003_beef)
        cmd(16'h1132, 16'h001e, 16'h0003, 16'h0008, 16'h0040, 200);
        `CHK({mem[64], mem[65], mem[66], mem[67]}, 64'h0003_0000_2211_0033)
        `CHK({mem[4], read_timeout_flag}, {16'h0001, 1'b0})
        $display("read test done");
    endtask
    task automatic t_tmo;
        u_peer.send(8'h44);
        mem[66] = 16'hbeef;
        cmd(16'h1132, 16'h0001, 16'h0002, 16'h0008, 16'h0040, 60);
        `CHK(mem[4], 16'hdead)
        wdone(300);
        `CHK({mem[4], cmd_status, read_timeout_flag}, {32'h0002_0002, 1'b1})
        `CHK({mem[66], rx_level}, 32'hbeef_0001)
        cmd(16'h1132, 16'h0000, 16'h0002, 16'h0008, 16'h0040, 400);
        `CHK(d, 1'b0)
        u_peer.send(8'h55);
        wdone(100);
        `CHK({mem[64], mem[66], read_timeout_flag}, {32'h0002_5544, 1'b0})
        $display("timeout test done");
    endtask
    task automatic t_ovf;
        for (int i = 1; i < 6; i++)
            u_peer.send(i[7:0]);
        pulse(3);
        pulse(4);
        `CHK({overflow_flag, framing_error_flag, parity_error_flag, rx_level}, {3'h7, 16'h0004})
        pulse(2);
        @(negedge clk_sys);
        `CHK({overflow_flag, framing_error_flag, parity_error_flag}, 3'h0)
        cmd(16'h1132, 16'h001e, 16'h0004, 16'h0008, 16'h0040, 200);
        `CHK({mem[66], mem[67]}, 32'h0201_0403)
        cmd(16'h1132, 16'h0000, 16'h0003, 16'h0008, 16'h0040, 80);
        cancel_type = 2'h2;
        pulse(1);
        repeat (5) @(negedge clk_sys);
        `CHK({cmd_busy, mem[4]}, {1'b0, 16'hdead})
        $display("overflow test done");
    endtask
    task automatic t_abort;
        for (int k = 0; k < 3; k++)
        begin
            pace = 2'h2;
            cmd(16'h1131, 16'h0000, 16'h0005, 16'h1111, 16'h2222, 80);
            cancel_type = k[1:0] | 2'h1;
            pulse(k != 0);
            repeat (5) @(negedge clk_sys);
            `CHK({d, cmd_busy, mem[4]}, {2'b00, 16'hdead})
        end
        $display("abort test done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        foreach (mem[i]) mem[i] = 16'h0000;
        {rst_n, cmd_start, cmd_base, init_req, cancel_req, cancel_type, status_read} = '0;
        {mem_rdata, rx_framing_err, rx_parity_err, pace} = '0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1;
        t_write;
        t_dial;
        t_read;
        t_tmo;
        t_ovf;
        t_abort;
        results;
    end
    initial
    begin
        #1000000;
        fails++;
        results;
    end
endmodule
`default_nettype wire
